// ### rtl/mac_cfg_pkg.sv
// Constants for the MAC transmit timing and PHY control block
package mac_cfg_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_MAC_CTRL3  = 8'h00;
  localparam logic [7:0] ADDR_HALF_DPX   = 8'h04;
  localparam logic [7:0] ADDR_B2B_GAP    = 8'h08;
  localparam logic [7:0] ADDR_PHY_CTRL1  = 8'h0C;
  localparam logic [7:0] ADDR_PHY_CTRL2  = 8'h10;
  localparam logic [7:0] ADDR_LED_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_STATUS     = 8'h18;
  // ==========================================================
  // Field positions
  localparam int TX_ENABLE_A_BIT   = 6;
  localparam int BPNB_BIT    = 5;
  localparam int NOBK_BIT    = 4;
  localparam int FDX_BIT     = 0;
  localparam int GAP_W       = 7;
  localparam int P1_LOOP_BIT = 14;
  localparam int P1_DPX_BIT  = 8;
  localparam int FRC_BIT     = 14;
  localparam int TXD_BIT     = 13;
  localparam int JAB_BIT     = 10;
  localparam int HDL_BIT     = 8;
  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0]  MAC3_MASK  = 8'h71;
  localparam logic [7:0]  HDX_MASK   = 8'h70;
  localparam logic [7:0]  GAP_MASK   = 8'h7F;
  localparam logic [15:0] P1_MASK    = 16'h4100;
  localparam logic [15:0] P2_MASK    = 16'h6500;
  localparam logic [15:0] LED_MASK   = 16'h0003;
  localparam logic [7:0]  RST8       = 8'h00;
  localparam logic [15:0] RST16      = 16'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : mac_cfg_pkg

// ### rtl/mac_tx_timing_phy_control.sv
// Register block for half-duplex transmit timing and PHY control
// How it works
// - Backpressure no-backoff set: retry at once after self-caused collision.
// - Backpressure no-backoff clear: backoff before retry after such collision.
// - No-backoff set: half duplex retries at once after any collision.
// - No-backoff clear: exponential backoff after any collision.
// - Seven-bit back-to-back gap in nibble times.
// - Force-link bit reports link up without partner.
// - Transmitter-disable bit turns off twisted-pair driver.
// - Jabber-disable bit stops jabber correction.
// - With control-one bits 8, 14 low, loopback-disable picks loopback.
// - Either control-one bit 8 or 14 high: loopback-disable ignored.
// - LED control register drives both LED outputs.
`timescale 1ns/1ns
`default_nettype none
module mac_tx_timing_phy_control
  import mac_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        link_detected,
  input  wire logic        tx_active,
  output logic             full_duplex,
  output logic             tx_enable_a_unlimited,
  output logic             bp_retry_now,
  output logic             any_retry_now,
  output logic [6:0]       back_to_back_gap_field,
  output logic             link_up,
  output logic             tp_tx_enable,
  output logic             jabber_enable,
  output logic             loopback_to_mac,
  output logic             led_output_one,
  output logic             led_output_two
);
  // ==========================================================
  // State
  // Bus side: registered readies, captured halves, pending answers
  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic        ardy;
    logic        awr;
    logic        wr;
    logic [7:0]  aw;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    // Software-visible registers, writable bits only
    logic [7:0]  mac_control_three;
    logic [7:0]  mac_half_duplex_control;
    logic [7:0]  back_to_back_gap;
    logic [15:0] phy_control_one;
    logic [15:0] phy_control_two;
    logic [15:0] phy_led_control;
    // Registered copies of the control outputs
    logic        fdx;
    logic        tx_enable_a;
    logic        bpn;
    logic        nbk;
    logic [6:0]  gap;
    logic        lnk;
    logic        txen;
    logic        jab;
    logic        loop;
    logic        led1;
    logic        led2;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Readies sit high through reset so the bus sees an idle slave
  localparam state_t ST_RESET = '{awrdy: 1'b1, wrdy: 1'b1, ardy: 1'b1, default: '0};

  // ==========================================================
  // Port timing
  // Write address and write data are captured on their own handshakes.
  // Either may arrive first; the captured half waits in the state.
  // The commit happens on the edge after both halves are held.
  // The write response is raised by that commit edge.
  // Readies drop while a half waits or while a response is pending.
  // Trade-off: no write overlap, but no skid buffer either.
  // One read in flight; its data is registered on the address edge.
  // Read data and response hold until rready is seen high.
  // Readies are flip-flops of their own, kept in step with the
  // pending flags, so no bus output has a combinational path.
  // Unmapped addresses answer with a slave error and change nothing.
  // The status word is read only; a write to it is refused the same way.
  // Only byte lanes 0 and 1 carry register bits; upper lanes are unused.

  // ==========================================================
  // Control outputs
  // Every control output is registered one edge after its register.
  // Software must allow that edge before relying on a new setting.
  // Half-duplex controls are forced low whenever full duplex is set,
  // so the transmit engine never sees a stale half-duplex mode.
  // The gap field is passed on as written; the host picks the offset
  // that suits the duplex mode, the block does not add it.
  // Link up follows the partner unless the force bit holds it up.
  // The loopback path depends on both PHY control registers at once.

  // ==========================================================
  // Clock enable
  // With the enable low nothing moves: bus state, registers and
  // outputs all hold. A bus master must not expect answers then.
  // Hazard: the partner's link level keeps moving while frozen,
  // so link up may lag it by the frozen span plus one edge.

  // ==========================================================
  // Byte-lane merge, used for every register write
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    return v & m;
  endfunction : merge16

  // Half-duplex-only control bit, forced off in full duplex
  // Used by all three collision and deferral controls
  function automatic logic hdx_only(input logic bit_v, input logic fdx_v);
    return bit_v && !fdx_v;
  endfunction : hdx_only

  // Register read mux; unmapped addresses answer with an error
  // Bit 32 of the result flags the error; the rest is the data word
  function automatic logic [32:0] rd_mux(input state_t s, input logic [7:0] a);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    unique case (a)
      ADDR_MAC_CTRL3: r[7:0]  = s.mac_control_three;
      ADDR_HALF_DPX:  r[7:0]  = s.mac_half_duplex_control;
      ADDR_B2B_GAP:   r[7:0]  = s.back_to_back_gap;
      ADDR_PHY_CTRL1: r[15:0] = s.phy_control_one;
      ADDR_PHY_CTRL2: r[15:0] = s.phy_control_two;
      ADDR_LED_CTRL:  r[15:0] = s.phy_led_control;
      ADDR_STATUS:    r[1:0]  = {s.lnk, s.loop};
      default:        r[32]   = 1'b1;
    endcase
    return r;
  endfunction : rd_mux

  // ==========================================================
  // Next state
  always_comb begin
    logic [32:0] rm;
    logic [15:0] ext8;
    rm = 33'h0_0000_0000;
    ext8 = 16'h0000;
    st_nxt = st_r;
    // Address and data latch independently, either order
    if (s_axi_awvalid && !st_r.awr && !st_r.bv) begin
      st_nxt.awr = 1'b1;
      st_nxt.aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.wr && !st_r.bv) begin
      st_nxt.wr = 1'b1;
      st_nxt.wd = s_axi_wdata;
      st_nxt.ws = s_axi_wstrb;
    end
    // Commit once both halves are held
    if (st_r.awr && st_r.wr) begin
      st_nxt.awr = 1'b0;
      st_nxt.wr = 1'b0;
      st_nxt.bv = 1'b1;
      st_nxt.br = RESP_OKAY;
      ext8 = {8'h00, st_r.mac_control_three};
      unique case (st_r.aw)
        ADDR_MAC_CTRL3: st_nxt.mac_control_three = 8'(merge16(ext8, st_r.wd, st_r.ws,
                                                   {8'h00, MAC3_MASK}));
        ADDR_HALF_DPX:  st_nxt.mac_half_duplex_control = 8'(merge16(
                          {8'h00, st_r.mac_half_duplex_control}, st_r.wd, st_r.ws,
                          {8'h00, HDX_MASK}));
        ADDR_B2B_GAP:   st_nxt.back_to_back_gap = 8'(merge16({8'h00, st_r.back_to_back_gap},
                          st_r.wd, st_r.ws, {8'h00, GAP_MASK}));
        ADDR_PHY_CTRL1: st_nxt.phy_control_one = merge16(st_r.phy_control_one, st_r.wd,
                          st_r.ws, P1_MASK);
        // Reserved bits dropped so they stay zero
        ADDR_PHY_CTRL2: st_nxt.phy_control_two = merge16(st_r.phy_control_two, st_r.wd,
                          st_r.ws, P2_MASK);
        ADDR_LED_CTRL:  st_nxt.phy_led_control = merge16(st_r.phy_led_control, st_r.wd,
                          st_r.ws, LED_MASK);
        ADDR_STATUS:    st_nxt.br = RESP_SLVERR;
        default:        st_nxt.br = RESP_SLVERR;
      endcase
    end
    if (st_r.bv && s_axi_bready) begin
      st_nxt.bv = 1'b0;
    end
    // Read path: one read in flight
    if (s_axi_arvalid && !st_r.rv) begin
      rm = rd_mux(st_r, s_axi_araddr);
      st_nxt.rv = 1'b1;
      st_nxt.rd = rm[31:0];
      st_nxt.rr = rm[32] ? RESP_SLVERR : RESP_OKAY;
    end else if (st_r.rv && s_axi_rready) begin
      st_nxt.rv = 1'b0;
    end
    // Half-duplex controls, inert in full duplex
    st_nxt.fdx = st_r.mac_control_three[FDX_BIT];
    st_nxt.tx_enable_a = hdx_only(st_r.mac_half_duplex_control[TX_ENABLE_A_BIT], st_nxt.fdx);
    st_nxt.bpn = hdx_only(st_r.mac_half_duplex_control[BPNB_BIT], st_nxt.fdx);
    st_nxt.nbk = hdx_only(st_r.mac_half_duplex_control[NOBK_BIT], st_nxt.fdx);
    st_nxt.gap = st_r.back_to_back_gap[GAP_W-1:0];
    // PHY controls
    st_nxt.lnk = link_detected || st_r.phy_control_two[FRC_BIT];
    st_nxt.txen = !st_r.phy_control_two[TXD_BIT];
    st_nxt.jab = !st_r.phy_control_two[JAB_BIT];
    // Loopback control only matters when control-one bits 8 and 14 are both low
    if (st_r.phy_control_one[P1_DPX_BIT] || st_r.phy_control_one[P1_LOOP_BIT]) begin
      st_nxt.loop = st_r.phy_control_one[P1_LOOP_BIT];
    end else begin
      st_nxt.loop = !st_r.phy_control_two[HDL_BIT];
    end
    // LED one shows activity when bit 0 is set, else link; LED two duplex when bit 1 is set, else activity
    st_nxt.led1 = st_r.phy_led_control[0] ? tx_active : st_nxt.lnk;
    st_nxt.led2 = st_r.phy_led_control[1] ? st_nxt.fdx : tx_active;
    // Readies registered from the next pending flags, so they stay in step
    st_nxt.awrdy = !st_nxt.awr && !st_nxt.bv;
    st_nxt.wrdy = !st_nxt.wr && !st_nxt.bv;
    st_nxt.ardy = !st_nxt.rv;
  end

  // ==========================================================
  // State register; clock enable freezes everything
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  // Each output is a plain state bit, no gates in front
  assign s_axi_awready = st_r.awrdy;
  assign s_axi_wready  = st_r.wrdy;
  assign s_axi_bvalid  = st_r.bv;
  assign s_axi_bresp   = st_r.br;
  assign s_axi_arready = st_r.ardy;
  assign s_axi_rvalid  = st_r.rv;
  assign s_axi_rdata   = st_r.rd;
  assign s_axi_rresp   = st_r.rr;
  assign full_duplex   = st_r.fdx;
  assign tx_enable_a_unlimited = st_r.tx_enable_a;
  assign bp_retry_now  = st_r.bpn;
  assign any_retry_now = st_r.nbk;
  assign back_to_back_gap_field = st_r.gap;
  assign link_up       = st_r.lnk;
  assign tp_tx_enable  = st_r.txen;
  assign jabber_enable = st_r.jab;
  assign loopback_to_mac = st_r.loop;
  assign led_output_one = st_r.led1;
  assign led_output_two = st_r.led2;
endmodule : mac_tx_timing_phy_control
`default_nettype wire

// ### verif/mac_tx_props_properties.sv
// Concurrent checks on the ports of the transmit timing and PHY control block
`timescale 1ns/1ns
`default_nettype none
module mac_tx_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        link_detected,
  input wire logic        link_up,
  input wire logic        full_duplex,
  input wire logic        tx_enable_a_unlimited,
  input wire logic        bp_retry_now,
  input wire logic        any_retry_now
);
  // ==========================================================
  // Bus handshakes, one clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after capture");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  resp_blocks_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_blocks_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:16] == 16'h0)
    else $error("read channel open or upper bits set");
  // ==========================================================
  // Configuration outputs
  freeze_hold_a: assert property (!ce |=> $stable(link_up) && $stable(full_duplex))
    else $error("state moved with clock enable low");
  link_follow_a: assert property (ce && link_detected |=> link_up)
    else $error("link up missing while partner seen");
  tx_enable_a_fdx_a: assert property (full_duplex |-> !tx_enable_a_unlimited)
    else $error("deferral active in full duplex");
  retry_fdx_a: assert property (full_duplex |-> !any_retry_now && !bp_retry_now)
    else $error("retry control active in full duplex");
endmodule : mac_tx_props
bind mac_tx_timing_phy_control mac_tx_props mac_tx_props_i (
  .clk, .rst, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .link_detected, .link_up, .full_duplex, .tx_enable_a_unlimited, .bp_retry_now, .any_retry_now);
`default_nettype wire

// ### verif/remote_station.sv
// Far-end station model: shows whether link pulses arrive
`timescale 1ns/1ns
`default_nettype none
module remote_station (
  input  wire logic clk,
  input  wire logic attach,
  output var logic  link_detected
);
  // Pulses seen one clock after the cable goes in; no partner at power-up
  initial link_detected = 1'h0;
  always @(posedge clk) link_detected <= attach;
endmodule : remote_station
`default_nettype wire

// ### verif/mac_tx_timing_phy_control_tb.sv
// Self-checking bench for the transmit timing and PHY control block
`timescale 1ns/1ns
`default_nettype none
module mac_tx_timing_phy_control_tb import mac_cfg_pkg::*;;
  logic        clk = 1'h0, rst = 1'h1, ce = 1'h1, attach = 1'h0, txa = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, link_det;
  logic [1:0]  bresp, rresp;
  logic        fdx, tx_enable_a, bpr, anyr, lnk, txe, jab, lpb, led1, led2;
  logic [6:0]  gap;
  logic [7:0]  gv [3] = '{8'h15, 8'h12, 8'hFF};
  int          errors = 0, num_checks = 0;
  mac_tx_timing_phy_control mac_tx_timing_phy_control_i (.clk(clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_detected(link_det), .tx_active(txa), .full_duplex(fdx), .tx_enable_a_unlimited(tx_enable_a),
    .bp_retry_now(bpr), .any_retry_now(anyr), .back_to_back_gap_field(gap), .link_up(lnk),
    .tp_tx_enable(txe), .jabber_enable(jab), .loopback_to_mac(lpb),
    .led_output_one(led1), .led_output_two(led2));
  remote_station remote_station_i (.clk(clk), .attach(attach), .link_detected(link_det));
  // ==========================================================
  // Clock and bus tasks
  always #4 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      errors++;
      $display("Error %s expected %h seen %h", n, ex, got);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ga = 1'h0, gw = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ga && gw)) begin
      @(posedge clk);
      if (!ga && awready) begin
        ga = 1'h1;
        awvalid <= 1'h0;
      end
      if (!gw && wready) begin
        gw = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'h0;
    chk("bresp", 32'(er), 32'(bresp));
    repeat (2) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'h0;
    chk("rresp", 32'(er), 32'(rresp));
    if (er === RESP_OKAY) chk("rdata", ex, rdata);
  endtask : rd
  task automatic summarize();
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // ==========================================================
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    errors++;
    summarize();
  end
  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h3, RESP_SLVERR);
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_HALF_DPX, 32'(v << 4), RESP_OKAY);
      chk("retry", 32'(v), 32'({tx_enable_a, bpr, anyr}));
    end
    wr(ADDR_MAC_CTRL3, 32'h1, RESP_OKAY);
    chk("fdx", 32'h8, 32'({fdx, tx_enable_a, bpr, anyr}));
    foreach (gv[i]) begin
      wr(ADDR_B2B_GAP, 32'(gv[i]), RESP_OKAY);
      chk("gap", 32'(gv[i] & GAP_MASK), 32'(gap));
    end
    rd(ADDR_B2B_GAP, 32'(GAP_MASK), RESP_OKAY);
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_PHY_CTRL2, {17'h0, v[2], v[1], 2'h0, v[0], 10'h0}, RESP_OKAY);
      chk("phy", 32'({v[2], !v[1], !v[0]}), 32'({lnk, txe, jab}));
    end
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_PHY_CTRL1, {17'h0, v[2], 5'h0, v[1], 8'h0}, RESP_OKAY);
      wr(ADDR_PHY_CTRL2, {23'h0, v[0], 8'h0}, RESP_OKAY);
      chk("loop", 32'((v[2] | v[1]) ? v[2] : !v[0]), 32'(lpb));
    end
    attach <= 1'h1;
    for (int c = 0; c < 8; c++) begin
      txa <= c[2];
      wr(ADDR_LED_CTRL, 32'(c & 3), RESP_OKAY);
      chk("led", 32'({c[0] ? c[2] : 1'h1, c[1] ? 1'h1 : c[2]}), 32'({led1, led2}));
    end
    // Back to half duplex, both duplex bits kept equal, loopback turned off
    wr(ADDR_MAC_CTRL3, 32'h0, RESP_OKAY);
    wr(ADDR_PHY_CTRL1, 32'h0, RESP_OKAY);
    rd(ADDR_PHY_CTRL1, 32'h0, RESP_OKAY);
    wr(ADDR_PHY_CTRL2, 32'h100, RESP_OKAY);
    chk("hdl", 32'h0, 32'(lpb));
    // Clock enable low must freeze the link indication
    ce <= 1'h0;
    attach <= 1'h0;
    repeat (4) @(posedge clk);
    chk("frozen", 32'h1, 32'(lnk));
    ce <= 1'h1;
    repeat (3) @(posedge clk);
    chk("link", 32'h0, 32'(lnk));
    summarize();
  end
endmodule : mac_tx_timing_phy_control_tb
`default_nettype wire
